// >>> rtl/act_pkg.sv
package act_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ACT_OFS_CTRL   = 4'h0;
  localparam logic [3:0] ACT_OFS_STATUS = 4'h1;
  localparam logic [3:0] ACT_OFS_RESULT = 4'h2;
  localparam logic [3:0] ACT_OFS_SYSCFG = 4'h3;

  // ---------------------------------------------------------------
  // Control field positions and reset values
  // ---------------------------------------------------------------
  localparam int ACT_CTRL_BCS_HI  = 15;
  localparam int ACT_CTRL_BCS_LO  = 14;
  localparam int ACT_CTRL_STS_HI  = 13;
  localparam int ACT_CTRL_STS_LO  = 12;
  localparam int ACT_CTRL_RES8    = 11;
  localparam int ACT_CTRL_PCAL    = 10;
  localparam int ACT_CTRL_START   = 0;
  localparam logic [15:0] ACT_CTRL_RESET = 16'h0400;

  localparam int ACT_STAT_BUSY = 0;
  localparam int ACT_STAT_DONE = 1;
  localparam int ACT_STAT_CAL  = 2;
  localparam int ACT_SYSCFG_HALVE = 0;

  // ---------------------------------------------------------------
  // Basic clock divisors, indexed by the basic clock select field
  // ---------------------------------------------------------------
  localparam logic [4:0] ACT_DIV_SEL0 = 5'h04;
  localparam logic [4:0] ACT_DIV_SEL1 = 5'h02;
  localparam logic [4:0] ACT_DIV_SEL2 = 5'h10;
  localparam logic [4:0] ACT_DIV_SEL3 = 5'h08;

  // ---------------------------------------------------------------
  // Timing in basic clock periods and system clock periods
  // ---------------------------------------------------------------
  localparam logic [6:0] ACT_ST_BASE     = 7'h08;
  localparam logic [6:0] ACT_CORE10_PCAL = 7'h34;
  localparam logic [6:0] ACT_CORE8_PCAL  = 7'h2C;
  localparam logic [6:0] ACT_PCAL_SAVE   = 7'h0C;
  localparam logic [2:0] ACT_LOAD_SYS    = 3'h6;
  localparam int         ACT_CAL_MIN_BC  = 484;
  localparam int         ACT_CAL_MAX_BC  = 11696;

  localparam logic [9:0] ACT_RES_ZERO = 10'h000;
  localparam logic [9:0] ACT_RES_FULL = 10'h3FF;

  // ---------------------------------------------------------------
  // Conversion sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ACT_IDLE,
    ACT_SAMPLE,
    ACT_CONVERT,
    ACT_LOAD
  } act_state_t;

endpackage : act_pkg

// >>> rtl/act_bc_div.sv
`timescale 1ns/10ps

module act_bc_div (
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [1:0] sel_i,
  input  wire logic       restart_i,
  output logic            tick_o
);
  import act_pkg::*;

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       tick_r;
  logic       tick_nxt;
  logic [4:0] div;

  // Divisor lookup for the selected basic clock.
  always_comb begin
    case (sel_i)
      2'b00:   div = ACT_DIV_SEL0;
      2'b01:   div = ACT_DIV_SEL1;
      2'b10:   div = ACT_DIV_SEL2;
      default: div = ACT_DIV_SEL3;
    endcase
  end

  // Restart aligns the first tick exactly one period after a start.
  // The tick is registered one count early, so it is acted on at the period's last edge.
  always_comb begin
    cnt_nxt = cnt_r + 5'h01;
    if (restart_i || (cnt_r >= div - 5'h01)) begin
      cnt_nxt = 5'h00;
    end
    tick_nxt = (cnt_nxt == div - 5'h01);
  end

  // Registers of the divider.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r  <= 5'h00;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;

endmodule : act_bc_div

// >>> rtl/act_sat.sv
`timescale 1ns/10ps

module act_sat (
  input  wire logic [9:0] code_i,
  input  wire logic       below_i,
  input  wire logic       above_i,
  input  wire logic       res8_i,
  output logic      [9:0] result_o
);
  import act_pkg::*;

  // Out-of-range inputs clamp; 8-bit results keep the upper bits.
  always_comb begin
    if (below_i) begin
      result_o = ACT_RES_ZERO;
    end else if (above_i) begin
      result_o = ACT_RES_FULL;
    end else if (res8_i) begin
      result_o = {code_i[9:2], 2'b00};
    end else begin
      result_o = code_i;
    end
  end

endmodule : act_sat

// >>> rtl/act_top.sv
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/10ps

module act_top #(
  parameter int CAL_BC = act_pkg::ACT_CAL_MIN_BC
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic [9:0]  ain_code_i,
  input  wire logic        ain_below_i,
  input  wire logic        ain_above_i,
  output logic             sample_o,
  output logic             busy_o,
  output logic             done_o,
  output logic             cal_active_o,
  output logic             cpu_clock_halve_o,
  output logic      [9:0]  result_o
);
  import act_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  act_state_t  state_r;
  act_state_t  state_nxt;
  logic [15:0] ctrl_r;
  logic [15:0] ctrl_nxt;
  logic        halve_r;
  logic        halve_nxt;
  logic [6:0]  tick_cnt_r;
  logic [6:0]  tick_cnt_nxt;
  logic [2:0]  load_cnt_r;
  logic [2:0]  load_cnt_nxt;
  logic [13:0] cal_cnt_r;
  logic [13:0] cal_cnt_nxt;
  logic        cal_r;
  logic        cal_nxt;
  logic        busy_r;
  logic        busy_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        sample_r;
  logic        sample_nxt;
  logic [9:0]  hold_r;
  logic [9:0]  hold_nxt;
  logic [9:0]  result_r;
  logic [9:0]  result_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        bc_tick;
  logic        start_req;
  logic        load_fire;
  logic [6:0]  sample_bc;
  logic [6:0]  core_bc;
  logic [9:0]  sat_value;

  // ---------------------------------------------------------------
  // Basic clock generation
  // ---------------------------------------------------------------
  // A start restarts the divider so tick spacing counts from the start.
  act_bc_div u_div (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sel_i     (ctrl_r[ACT_CTRL_BCS_HI:ACT_CTRL_BCS_LO]),
    .restart_i (start_req),
    .tick_o    (bc_tick)
  );

  // Saturation and result formatting of the sampled code.
  act_sat u_sat (
    .code_i   (ain_code_i),
    .below_i  (ain_below_i),
    .above_i  (ain_above_i),
    .res8_i   (ctrl_r[ACT_CTRL_RES8]),
    .result_o (sat_value)
  );

  // ---------------------------------------------------------------
  // Timing selection
  // ---------------------------------------------------------------
  // Sample length doubles with each step of the select field.
  always_comb begin
    sample_bc = ACT_ST_BASE << ctrl_r[ACT_CTRL_STS_HI:ACT_CTRL_STS_LO];
  end

  // Core length depends on resolution and post-calibration.
  always_comb begin
    if (ctrl_r[ACT_CTRL_RES8]) begin
      core_bc = ACT_CORE8_PCAL;
    end else begin
      core_bc = ACT_CORE10_PCAL;
    end
    if (!ctrl_r[ACT_CTRL_PCAL]) begin
      core_bc = core_bc - ACT_PCAL_SAVE;
    end
  end

  // A start is accepted only when no conversion is running.
  assign start_req = wr_i && (addr_i == ACT_OFS_CTRL) && wdata_i[ACT_CTRL_START]
                     && (state_r == ACT_IDLE);
  // The start write cycle is the first of the trailing system clocks.
  assign load_fire = (state_r == ACT_LOAD) && (load_cnt_r == ACT_LOAD_SYS - 3'h2);

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  // Sample and decide phases counted in basic clock ticks, load phase counted on the system clock.
  always_comb begin
    state_nxt    = state_r;
    tick_cnt_nxt = tick_cnt_r;
    load_cnt_nxt = load_cnt_r;
    sample_nxt   = sample_r;
    hold_nxt     = hold_r;
    result_nxt   = result_r;
    case (state_r)
      ACT_IDLE: begin
        if (start_req) begin
          state_nxt    = ACT_SAMPLE;
          tick_cnt_nxt = 7'h00;
          sample_nxt   = 1'b1;
        end
      end
      ACT_SAMPLE: begin
        if (bc_tick) begin
          if (tick_cnt_r == sample_bc - 7'h01) begin
            state_nxt    = ACT_CONVERT;
            tick_cnt_nxt = 7'h00;
            sample_nxt   = 1'b0;
            hold_nxt     = sat_value;
          end else begin
            tick_cnt_nxt = tick_cnt_r + 7'h01;
          end
        end
      end
      ACT_CONVERT: begin
        if (bc_tick) begin
          if (tick_cnt_r == core_bc - 7'h01) begin
            state_nxt    = ACT_LOAD;
            load_cnt_nxt = 3'h0;
          end else begin
            tick_cnt_nxt = tick_cnt_r + 7'h01;
          end
        end
      end
      ACT_LOAD: begin
        load_cnt_nxt = load_cnt_r + 3'h1;
        if (load_fire) begin
          state_nxt  = ACT_IDLE;
          result_nxt = hold_r;
        end
      end
      default: begin
        state_nxt  = ACT_IDLE;
        sample_nxt = 1'b0;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r    <= ACT_IDLE;
      tick_cnt_r <= 7'h00;
      load_cnt_r <= 3'h0;
      sample_r   <= 1'b0;
      hold_r     <= 10'h000;
      result_r   <= 10'h000;
    end else begin
      state_r    <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      load_cnt_r <= load_cnt_nxt;
      sample_r   <= sample_nxt;
      hold_r     <= hold_nxt;
      result_r   <= result_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Reset calibration
  // ---------------------------------------------------------------
  // Counts basic clocks while idle; a conversion pauses it.
  always_comb begin
    cal_nxt     = cal_r;
    cal_cnt_nxt = cal_cnt_r;
    if (cal_r && bc_tick && (state_r == ACT_IDLE)) begin
      if (cal_cnt_r == 14'(CAL_BC - 1)) begin
        cal_nxt = 1'b0;
      end else begin
        cal_cnt_nxt = cal_cnt_r + 14'h0001;
      end
    end
  end

  // Calibration registers.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_r     <= 1'b1;
      cal_cnt_r <= 14'h0000;
    end else begin
      cal_r     <= cal_nxt;
      cal_cnt_r <= cal_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Busy follows a start; done sets on load and a set beats a clear.
  always_comb begin
    busy_nxt = busy_r;
    done_nxt = done_r;
    if (wr_i && (addr_i == ACT_OFS_STATUS) && wdata_i[ACT_STAT_DONE]) begin
      done_nxt = 1'b0;
    end
    if (start_req) begin
      busy_nxt = 1'b1;
    end
    if (load_fire) begin
      busy_nxt = 1'b0;
      done_nxt = 1'b1;
    end
  end

  // Status registers.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  // Writes to control and system configuration; start bit is not stored.
  always_comb begin
    ctrl_nxt  = ctrl_r;
    halve_nxt = halve_r;
    if (wr_i && (addr_i == ACT_OFS_CTRL)) begin
      ctrl_nxt = wdata_i & 16'hFFFE;
    end
    if (wr_i && (addr_i == ACT_OFS_SYSCFG)) begin
      halve_nxt = wdata_i[ACT_SYSCFG_HALVE];
    end
  end

  // Read data appear in the cycle after the read strobe only.
  always_comb begin
    rdata_nxt = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        ACT_OFS_CTRL:   rdata_nxt = ctrl_r;
        ACT_OFS_STATUS: rdata_nxt = {13'h0, cal_r, done_r, busy_r};
        ACT_OFS_RESULT: rdata_nxt = {6'h00, result_r};
        ACT_OFS_SYSCFG: rdata_nxt = {15'h0, halve_r};
        default:        rdata_nxt = 16'h0000;
      endcase
    end
  end

  // Register port state.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r  <= ACT_CTRL_RESET;
      halve_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      ctrl_r  <= ctrl_nxt;
      halve_r <= halve_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata_o           = rdata_r;
  assign sample_o          = sample_r;
  assign busy_o            = busy_r;
  assign done_o            = done_r;
  assign cal_active_o      = cal_r;
  assign cpu_clock_halve_o = halve_r;
  assign result_o          = result_r;

endmodule : act_top

// >>> testbench/act_top_asserts.sv
`timescale 1ns/10ps

module act_top_asserts #(
  parameter int CAL_BC = 4
) (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [3:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic        sample_o,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        cal_active_o,
  input wire logic        cpu_clock_halve_o,
  input wire logic [9:0]  result_o
);
  import act_pkg::*;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // An accepted start and a done clear, decoded from the bus.
  wire start_w = wr_i && addr_i == ACT_OFS_CTRL && wdata_i[ACT_CTRL_START] && !busy_o;
  wire clr_w   = wr_i && addr_i == ACT_OFS_STATUS && wdata_i[ACT_STAT_DONE];

  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  chk_start_busy: assert property (start_w |=> busy_o && sample_o)
    else $error("start did not raise busy and sample");
  chk_sample_busy: assert property (sample_o |-> busy_o)
    else $error("sample outside a conversion");
  chk_sample_min: assert property ($rose(sample_o) |-> sample_o [*8])
    else $error("sample phase too short");
  chk_done_load: assert property ($fell(busy_o) |-> done_o && !sample_o)
    else $error("done not set at result load");
  chk_result_load: assert property ($changed(result_o) |-> $fell(busy_o))
    else $error("result changed outside load");
  chk_done_hold: assert property (done_o && !clr_w |=> done_o)
    else $error("done lost without clear");
  chk_cal_once: assert property (!cal_active_o |=> !cal_active_o)
    else $error("calibration restarted");
  chk_halve_copy: assert property (wr_i && addr_i == ACT_OFS_SYSCFG |=>
    cpu_clock_halve_o == $past(wdata_i[ACT_SYSCFG_HALVE]))
    else $error("clock halve bit not copied");
  chk_read_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read cycle");

  // Main scenarios reached.
  cov_load: cover property ($fell(busy_o));
  cov_cal:  cover property ($fell(cal_active_o));
  cov_clr:  cover property (done_o && clr_w);
endmodule : act_top_asserts

bind act_top act_top_asserts #(.CAL_BC(CAL_BC)) u_act_top_asserts (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_o(sample_o),
  .busy_o(busy_o), .done_o(done_o), .cal_active_o(cal_active_o),
  .cpu_clock_halve_o(cpu_clock_halve_o), .result_o(result_o)
);

// >>> testbench/act_ain_model.sv
`timescale 1ns/10ps

module act_ain_model (
  input  wire logic       clk_i,
  input  wire logic       sample_i,
  input  wire logic [9:0] code_i,
  input  wire logic       below_i,
  input  wire logic       above_i,
  output logic      [9:0] ain_code_o,
  output logic            ain_below_o,
  output logic            ain_above_o
);
  logic flip_r = 1'b0;

  // Toggles every cycle so the odd code bits move while not sampling.
  always_ff @(posedge clk_i) begin
    flip_r <= ~flip_r;
  end

  // The set level shows only while sampling; otherwise the inverse, with the odd code bits toggling.
  always_comb begin
    ain_code_o  = sample_i ? code_i : ~code_i ^ {5{flip_r, 1'b0}};
    ain_below_o = sample_i ? below_i : ~below_i;
    ain_above_o = sample_i ? above_i : ~above_i;
  end
endmodule : act_ain_model

// >>> testbench/tb_act_top.sv
`timescale 1ns/10ps

module tb_act_top;
  import act_pkg::*;

  localparam int CAL_BC = 4;

  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [9:0]  v_code = 10'h000;
  logic        v_below = 1'b0;
  logic        v_above = 1'b0;
  logic [15:0] rdata_o;
  logic [9:0]  ain_code;
  logic        ain_below;
  logic        ain_above;
  logic        sample_o;
  logic        busy_o;
  logic        done_o;
  logic        cal_active_o;
  logic        cpu_clock_halve_o;
  logic [9:0]  result_o;
  int          n_fail = 0;
  int          total_checks = 0;
  int          cycles = 0;

  act_top #(.CAL_BC(CAL_BC)) u_act_top (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ain_code_i(ain_code),
    .ain_below_i(ain_below), .ain_above_i(ain_above), .sample_o(sample_o),
    .busy_o(busy_o), .done_o(done_o), .cal_active_o(cal_active_o),
    .cpu_clock_halve_o(cpu_clock_halve_o), .result_o(result_o)
  );

  act_ain_model u_act_ain_model (
    .clk_i(clk_i), .sample_i(sample_o), .code_i(v_code), .below_i(v_below),
    .above_i(v_above), .ain_code_o(ain_code), .ain_below_o(ain_below),
    .ain_above_o(ain_above)
  );

  // Clock of 40 ns period.
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // Cycle count with a ceiling that cuts a hang short.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_count(input int got, input int exp, input string what);
    total_checks++;
    if (got != exp) begin
      n_fail++;
      $display("ERROR %0t %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask : cmp_count

  // One write cycle, then one settled step past the taking edge.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // One read cycle; data taken in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // Expected conversion length in system clocks.
  function automatic int conv_len(input logic [1:0] s, input logic [1:0] t,
                                  input logic r8, input logic pc);
    int n;
    n = (s == 2'h0) ? 4 : (s == 2'h1) ? 2 : (s == 2'h2) ? 16 : 8;
    return n * ((8 << t) + (r8 ? 44 : 52) - (pc ? 0 : 12)) + 6;
  endfunction : conv_len

  // Starts a conversion, optionally retries start mid-run, waits for load.
  task automatic conv(input logic [1:0] s, input logic [1:0] t, input logic r8,
                      input logic pc, input logic [9:0] c, input logic b,
                      input logic a, input logic retry, output int n);
    int c0;
    @(posedge clk_i);
    v_code  <= c;
    v_below <= b;
    v_above <= a;
    wr(ACT_OFS_CTRL, {s, t, r8, pc, 9'h000, 1'b1});
    c0 = cycles;
    // The retry keeps the fields, so only the refused start bit differs.
    if (retry) begin
      wr(ACT_OFS_CTRL, {s, t, r8, pc, 9'h000, 1'b1});
    end
    while (busy_o === 1'b1 && cycles - c0 < 4000) begin
      @(posedge clk_i);
      #1;
    end
    n = cycles - c0 + 1;
  endtask : conv

  task automatic t_reset();
    logic [15:0] d;
    int c0;
    rd(ACT_OFS_STATUS, d);
    cmp_word(d, 16'h0004, "status after reset");
    rd(ACT_OFS_CTRL, d);
    cmp_word(d, 16'h0400, "control after reset");
    wr(4'hF, 16'hFFFF);
    rd(4'hF, d);
    cmp_word(d, 16'h0000, "unmapped read");
    c0 = cycles;
    while (cal_active_o === 1'b1 && cycles - c0 < 200) begin
      @(posedge clk_i);
      #1;
    end
    cmp_count(cycles - 20, 4 * CAL_BC, "calibration length");
  endtask : t_reset

  task automatic t_conv(input logic [1:0] s, input logic [1:0] t, input logic r8,
                        input logic pc, input logic [9:0] c, input logic b,
                        input logic a, input logic [9:0] exp);
    logic [15:0] d;
    int n;
    conv(s, t, r8, pc, c, b, a, 1'b0, n);
    cmp_count(n, conv_len(s, t, r8, pc), "duration");
    cmp_word({6'h00, result_o}, {6'h00, exp}, "result");
    rd(ACT_OFS_STATUS, d);
    cmp_word(d, 16'h0002, "done flag");
    wr(ACT_OFS_STATUS, 16'h0002);
    rd(ACT_OFS_STATUS, d);
    cmp_word(d, 16'h0000, "done cleared");
  endtask : t_conv

  task automatic t_refuse();
    int n;
    conv(2'h1, 2'h0, 1'b0, 1'b1, 10'h0F0, 1'b0, 1'b0, 1'b1, n);
    cmp_count(n, conv_len(2'h1, 2'h0, 1'b0, 1'b1), "start while busy");
    cmp_word({6'h00, result_o}, 16'h00F0, "result kept");
  endtask : t_refuse

  task automatic t_halve();
    logic [15:0] d;
    wr(ACT_OFS_SYSCFG, 16'h0001);
    cmp_word({15'h0, cpu_clock_halve_o}, 16'h0001, "halve set");
    rd(ACT_OFS_SYSCFG, d);
    cmp_word(d, 16'h0001, "halve readback");
    wr(ACT_OFS_SYSCFG, 16'h0000);
    cmp_word({15'h0, cpu_clock_halve_o}, 16'h0000, "halve clear");
  endtask : t_halve

  // Reset for 20 cycles, then every scenario in turn.
  // At 25 MHz the chosen divisors keep the basic clock within its legal range.
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_conv(2'h0, 2'h0, 1'b0, 1'b1, 10'h155, 1'b0, 1'b0, 10'h155);
    t_conv(2'h1, 2'h1, 1'b1, 1'b1, 10'h2AB, 1'b0, 1'b0, 10'h2A8);
    t_conv(2'h2, 2'h2, 1'b0, 1'b0, 10'h1FF, 1'b1, 1'b0, 10'h000);
    t_conv(2'h3, 2'h3, 1'b1, 1'b0, 10'h0AA, 1'b0, 1'b1, 10'h3FF);
    t_refuse();
    t_halve();
    conclude();
  end
endmodule : tb_act_top
